/* File: design/pms_regs.vh */
// Register map, field positions, reset values and timing counts
`ifndef PMS_REGS_VH
`define PMS_REGS_VH
// Register word addresses (byte address = offset)
`define PMS_CTRL_ADDR      8'h00
`define PMS_STAT_ADDR      8'h04
`define PMS_CYC_LIM_ADDR   8'h08
`define PMS_SUBST_ADDR     8'h0c
`define PMS_FW_ADDR        8'h10
`define PMS_MPI_ADDR       8'h14
// Control fields (write)
`define PMS_CTRL_KICK      0
`define PMS_CTRL_CYC_END   1
`define PMS_CTRL_BP_HIT    2
`define PMS_CTRL_RESUME    3
`define PMS_CTRL_STEP      4
`define PMS_CTRL_STEP_DONE 5
`define PMS_CTRL_LOAD_DONE 6
`define PMS_CTRL_FACTORY   7
`define PMS_CTRL_FW_GO     8
`define PMS_CTRL_SUBST_EN  9
`define PMS_CTRL_BP_LO     12
`define PMS_CTRL_ERASE_OK  10
// Mode codes
`define PMS_MODE_STOP      3'h0
`define PMS_MODE_START     3'h1
`define PMS_MODE_RUN       3'h2
`define PMS_MODE_HOLD      3'h3
`define PMS_MODE_ERASE     3'h4
`define PMS_MODE_RELOAD    3'h5
// Run phase codes
`define PMS_PH_IDLE        3'h0
`define PMS_PH_CLR_IN      3'h1
`define PMS_PH_STARTUP     3'h2
`define PMS_PH_CLR_OUT     3'h3
`define PMS_PH_RD_IN       3'h4
`define PMS_PH_CYCLIC      3'h5
`define PMS_PH_WR_OUT      3'h6
// Reset values and times
`define PMS_MPI_DEFAULT    8'h02
`define PMS_CYC_LIM_RST    16'h0064
`define PMS_WDOG_MS        100
`define PMS_HOLD_MS        3000
`define PMS_DEB_MS         10
`define PMS_BLINK_MS       250
`define PMS_CLK_KHZ        25000
`define PMS_PKG_PREFIX     16'h7078
`endif

/* File: design/pms_sequencer.v */
// Operating-mode sequencer with watchdog, cycle supervision, memory reset
`timescale 1ns/100ps
`include "pms_regs.vh"

module pms_sequencer #(
    parameter MS_CYCLES  = `PMS_CLK_KHZ,
    parameter WDOG_MS    = `PMS_WDOG_MS,
    parameter HOLD_MS    = `PMS_HOLD_MS,
    parameter DEB_MS     = `PMS_DEB_MS,
    parameter BLINK_MS   = `PMS_BLINK_MS
) (
    // Clock and reset
    input  wire        clock_in,
    input  wire        nrst_in,
    // Wishbone slave
    input  wire        wb_cyc_in,
    input  wire        wb_stb_in,
    input  wire        wb_we_in,
    input  wire [7:0]  wb_adr_in,
    input  wire [3:0]  wb_sel_in,
    input  wire [31:0] wb_dat_in,
    output reg  [31:0] wb_dat_out,
    output reg         wb_ack_out,
    // Front panel switch and card
    input  wire        sw_run_in,
    input  wire        sw_mres_in,
    input  wire        card_image_in,
    input  wire        card_pkg_in,
    input  wire [15:0] card_pkg_prefix_in,
    input  wire [23:0] card_pkg_ver_in,
    input  wire [23:0] fw_ver_in,
    // Remote inputs
    input  wire [7:0]  remote_in,
    // Indicators and controls
    output reg         run_indicator_out,
    output reg         halt_indicator_out,
    output reg         card_indicator_out,
    output reg         output_inhibit_out,
    output reg         core_reset_out,
    output reg         timers_run_out,
    output reg         erase_mem_out,
    output reg         fw_pending_out,
    output reg  [2:0]  phase_out,
    output reg  [2:0]  mode_out,
    output reg  [15:0] ao_level_out,
    output reg  [7:0]  remote_image_out,
    output reg  [31:0] rtc_out
);

////////////////////////////////////////////////////////////////////////////
localparam ARM_IDLE = 2'h0;
localparam ARM_HELD = 2'h1;
localparam ARM_READY = 2'h2;
localparam ARM_TAP  = 2'h3;

function [15:0] safe_level;
    input       subst_en;
    input [15:0] subst;
    begin
        safe_level = subst_en ? subst : 16'h0000;
    end
endfunction

// Millisecond tick
reg [15:0] ms_cnt_r;
reg        ms_tick_r;
always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
        ms_cnt_r  <= 16'h0000;
        ms_tick_r <= 1'b0;
    end else begin
        ms_tick_r <= (ms_cnt_r == MS_CYCLES - 1);
        if (ms_cnt_r == MS_CYCLES - 1)
            ms_cnt_r <= 16'h0000;
        else
            ms_cnt_r <= ms_cnt_r + 16'h0001;
    end
end

////////////////////////////////////////////////////////////////////////////
// switch sync, debounce
reg [1:0] sw_s1_r, sw_s2_r, sw_deb_r;
reg [7:0] deb_cnt_r;
reg [7:0] rem_s1_r, rem_s2_r;
always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
        sw_s1_r   <= 2'h0;
        sw_s2_r   <= 2'h0;
        sw_deb_r  <= 2'h0;
        deb_cnt_r <= 8'h00;
        rem_s1_r  <= 8'h00;
        rem_s2_r  <= 8'h00;
    end else begin
        sw_s1_r  <= {sw_mres_in, sw_run_in};
        sw_s2_r  <= sw_s1_r;
        rem_s1_r <= remote_in;
        rem_s2_r <= rem_s1_r;
        if (sw_s2_r == sw_deb_r)
            deb_cnt_r <= 8'h00;
        else if (ms_tick_r) begin
            if (deb_cnt_r == DEB_MS[7:0]) begin
                sw_deb_r  <= sw_s2_r;
                deb_cnt_r <= 8'h00;
            end else
                deb_cnt_r <= deb_cnt_r + 8'h01;
        end
    end
end
wire sw_run  = sw_deb_r[0];
wire sw_mres = sw_deb_r[1];

////////////////////////////////////////////////////////////////////////////
// Register bus
reg [15:0] cyc_lim_r, subst_r;
reg        subst_en_r, erase_ok_r;
reg [2:0]  bp_cnt_r;
reg [7:0]  mpi_r;
reg [31:0] ctrl_pulse_r;
reg        wdog_trip_r, cyc_trip_r, step_refused_r;
wire wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
wire wb_wr  = wb_req && wb_we_in && wb_sel_in[0];
always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
        wb_ack_out   <= 1'b0;
        wb_dat_out   <= 32'h00000000;
        cyc_lim_r    <= `PMS_CYC_LIM_RST;
        subst_r      <= 16'h0000;
        subst_en_r   <= 1'b0;
        bp_cnt_r     <= 3'h0;
        ctrl_pulse_r <= 32'h00000000;
    end else begin
        wb_ack_out   <= wb_req;
        ctrl_pulse_r <= 32'h00000000;
        if (wb_wr && wb_adr_in == `PMS_CTRL_ADDR) begin
            ctrl_pulse_r <= wb_dat_in;
            subst_en_r   <= wb_dat_in[`PMS_CTRL_SUBST_EN];
            bp_cnt_r     <= wb_dat_in[`PMS_CTRL_BP_LO+2:`PMS_CTRL_BP_LO];
        end
        if (wb_wr && wb_adr_in == `PMS_CYC_LIM_ADDR)
            cyc_lim_r <= (wb_dat_in[15:0] == 16'h0000) ?
                         16'h0001 : wb_dat_in[15:0];
        if (wb_wr && wb_adr_in == `PMS_SUBST_ADDR)
            subst_r <= wb_dat_in[15:0];
        case (wb_adr_in)
            `PMS_CTRL_ADDR:    wb_dat_out <= {17'h0, bp_cnt_r, 2'h0,
                                              subst_en_r, 9'h0};
            `PMS_STAT_ADDR:    wb_dat_out <= {21'h0, step_refused_r,
                                              cyc_trip_r, wdog_trip_r,
                                              fw_pending_out, phase_out,
                                              1'b0, mode_out};
            `PMS_CYC_LIM_ADDR: wb_dat_out <= {16'h0, cyc_lim_r};
            `PMS_SUBST_ADDR:   wb_dat_out <= {16'h0, subst_r};
            `PMS_FW_ADDR:      wb_dat_out <= {8'h0, card_pkg_ver_in};
            `PMS_MPI_ADDR:     wb_dat_out <= {24'h0, mpi_r};
            default:           wb_dat_out <= 32'h00000000;
        endcase
    end
end
wire c_kick   = ctrl_pulse_r[`PMS_CTRL_KICK];
wire c_cycend = ctrl_pulse_r[`PMS_CTRL_CYC_END];
wire c_bp     = ctrl_pulse_r[`PMS_CTRL_BP_HIT];
wire c_resume = ctrl_pulse_r[`PMS_CTRL_RESUME];
wire c_step   = ctrl_pulse_r[`PMS_CTRL_STEP];
wire c_done   = ctrl_pulse_r[`PMS_CTRL_STEP_DONE];
wire c_load   = ctrl_pulse_r[`PMS_CTRL_LOAD_DONE];
wire c_fact   = ctrl_pulse_r[`PMS_CTRL_FACTORY];
wire c_fwgo   = ctrl_pulse_r[`PMS_CTRL_FW_GO];
wire c_eraok  = ctrl_pulse_r[`PMS_CTRL_ERASE_OK];

////////////////////////////////////////////////////////////////////////////
// Mode state machine
reg [2:0]  mode_r, phase_r;
reg [1:0]  arm_r;
reg [15:0] arm_ms_r, wd_ms_r, cyc_ms_r, blink_ms_r;
reg        blink_r, stepping_r, fw_chk_r;
wire       in_run = (mode_r == `PMS_MODE_RUN);
wire       running = (mode_r == `PMS_MODE_RUN) ||
                     (mode_r == `PMS_MODE_START);
wire       pkg_ok = card_pkg_in &&
                    (card_pkg_prefix_in == `PMS_PKG_PREFIX);

always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
        mode_r         <= `PMS_MODE_STOP;
        phase_r        <= `PMS_PH_IDLE;
        arm_r          <= ARM_IDLE;
        arm_ms_r       <= 16'h0000;
        wd_ms_r        <= 16'h0000;
        cyc_ms_r       <= 16'h0000;
        wdog_trip_r    <= 1'b0;
        cyc_trip_r     <= 1'b0;
        step_refused_r <= 1'b0;
        stepping_r     <= 1'b0;
        fw_chk_r       <= 1'b1;
        fw_pending_out <= 1'b0;
        erase_ok_r     <= 1'b0;
        mpi_r          <= `PMS_MPI_DEFAULT;
        core_reset_out <= 1'b0;
        erase_mem_out  <= 1'b0;
        remote_image_out <= 8'h00;
    end else begin
        core_reset_out <= 1'b0;
        if (!running || c_kick)
            wd_ms_r <= 16'h0000;
        else if (ms_tick_r && mode_r != `PMS_MODE_HOLD)
            wd_ms_r <= wd_ms_r + 16'h0001;
        if (!in_run || c_cycend)
            cyc_ms_r <= 16'h0000;
        else if (ms_tick_r)
            cyc_ms_r <= cyc_ms_r + 16'h0001;
        // remote inputs read cyclically in STOP
        if (mode_r == `PMS_MODE_STOP && ms_tick_r)
            remote_image_out <= rem_s2_r;
        // firmware check once after power-on in STOP
        if (fw_chk_r && mode_r == `PMS_MODE_STOP && !sw_run) begin
            fw_chk_r       <= 1'b0;
            fw_pending_out <= pkg_ok && (card_pkg_ver_in != fw_ver_in);
        end else if (c_fwgo && fw_pending_out)
            fw_pending_out <= 1'b0;
        if (c_fact && mode_r == `PMS_MODE_STOP) begin
            mpi_r         <= `PMS_MPI_DEFAULT;
            erase_mem_out <= 1'b1;
        end
        if (wd_ms_r >= WDOG_MS[15:0] && running) begin
            wdog_trip_r    <= 1'b1;
            core_reset_out <= 1'b1;
            mode_r         <= `PMS_MODE_STOP;
            phase_r        <= `PMS_PH_IDLE;
        end else if (in_run && cyc_ms_r > cyc_lim_r) begin
            cyc_trip_r <= 1'b1;
            mode_r     <= `PMS_MODE_STOP;
            phase_r    <= `PMS_PH_IDLE;
        end else begin
            case (mode_r)
                `PMS_MODE_STOP: begin
                    // Fault stop holds until switch returns to STOP
                    if (!sw_run) begin
                        wdog_trip_r <= 1'b0;
                        cyc_trip_r  <= 1'b0;
                    end
                    if (sw_run && !sw_mres &&
                        !wdog_trip_r && !cyc_trip_r) begin
                        mode_r      <= `PMS_MODE_START;
                        phase_r     <= `PMS_PH_CLR_IN;
                        wdog_trip_r <= 1'b0;
                        cyc_trip_r  <= 1'b0;
                        arm_r       <= ARM_IDLE;
                    end
                    if (ms_tick_r && arm_ms_r != 16'hffff)
                        arm_ms_r <= arm_ms_r + 16'h0001;
                    case (arm_r)
                        ARM_IDLE: begin
                            if (!sw_mres)
                                arm_ms_r <= 16'h0000;
                            else if (arm_ms_r >= HOLD_MS[15:0]) begin
                                arm_r    <= ARM_HELD;
                            end
                        end
                        ARM_HELD: begin
                            if (!sw_mres) begin
                                arm_r    <= ARM_READY;
                                arm_ms_r <= 16'h0000;
                            end
                        end
                        ARM_READY: begin
                            if (sw_mres)
                                arm_r <= ARM_TAP;
                            else if (arm_ms_r >= HOLD_MS[15:0])
                                arm_r <= ARM_IDLE;
                        end
                        ARM_TAP: begin
                            if (!sw_mres && arm_ms_r < HOLD_MS[15:0]) begin
                                mode_r        <= `PMS_MODE_ERASE;
                                erase_mem_out <= 1'b1;
                                erase_ok_r    <= 1'b0;
                                arm_r         <= ARM_IDLE;
                            end else if (arm_ms_r >= HOLD_MS[15:0])
                                arm_r <= ARM_IDLE;
                        end
                        default: arm_r <= ARM_IDLE;
                    endcase
                end
                `PMS_MODE_ERASE: begin
                    if (c_eraok) begin
                        erase_mem_out <= 1'b0;
                        erase_ok_r    <= 1'b1;
                        // reload from card if image present
                        mode_r <= card_image_in ? `PMS_MODE_RELOAD :
                                                  `PMS_MODE_STOP;
                    end
                end
                `PMS_MODE_RELOAD: begin
                    if (c_load) begin
                        mode_r  <= sw_run ? `PMS_MODE_START :
                                            `PMS_MODE_STOP;
                        phase_r <= sw_run ? `PMS_PH_CLR_IN : `PMS_PH_IDLE;
                    end
                end
                `PMS_MODE_START: begin
                    case (phase_r)
                        `PMS_PH_CLR_IN: begin
                            remote_image_out <= rem_s2_r;
                            phase_r          <= `PMS_PH_STARTUP;
                        end
                        default: if (c_done) begin
                            mode_r  <= `PMS_MODE_RUN;
                            phase_r <= `PMS_PH_CLR_OUT;
                        end
                    endcase
                end
                `PMS_MODE_RUN: begin
                    if (!sw_run) begin
                        mode_r  <= `PMS_MODE_STOP;
                        phase_r <= `PMS_PH_IDLE;
                    end else if (c_bp) begin
                        mode_r <= `PMS_MODE_HOLD;
                    end else begin
                        case (phase_r)
                            `PMS_PH_CLR_OUT: phase_r <= `PMS_PH_RD_IN;
                            `PMS_PH_RD_IN: begin
                                remote_image_out <= rem_s2_r;
                                phase_r <= `PMS_PH_CYCLIC;
                            end
                            `PMS_PH_CYCLIC:
                                if (c_done) phase_r <= `PMS_PH_WR_OUT;
                            default: phase_r <= `PMS_PH_RD_IN;
                        endcase
                    end
                end
                `PMS_MODE_HOLD: begin
                    if (c_step) begin
                        step_refused_r <= (bp_cnt_r > 3'h2);
                        stepping_r     <= (bp_cnt_r <= 3'h2);
                    end
                    if (!sw_run) begin
                        mode_r  <= `PMS_MODE_STOP;
                        phase_r <= `PMS_PH_IDLE;
                    end else if (c_resume)
                        mode_r <= `PMS_MODE_RUN;
                end
                default: mode_r <= `PMS_MODE_STOP;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Indicators, inhibit and real-time clock
always @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
        blink_ms_r         <= 16'h0000;
        blink_r            <= 1'b0;
        run_indicator_out  <= 1'b0;
        halt_indicator_out <= 1'b0;
        card_indicator_out <= 1'b0;
        output_inhibit_out <= 1'b1;
        timers_run_out     <= 1'b0;
        ao_level_out       <= 16'h0000;
        rtc_out            <= 32'h00000000;
        phase_out          <= `PMS_PH_IDLE;
        mode_out           <= `PMS_MODE_STOP;
    end else begin
        mode_out  <= mode_r;
        phase_out <= phase_r;
        if (ms_tick_r) begin
            if (blink_ms_r == BLINK_MS[15:0] - 16'h0001) begin
                blink_ms_r <= 16'h0000;
                blink_r    <= ~blink_r;
            end else
                blink_ms_r <= blink_ms_r + 16'h0001;
        end
        if (ms_tick_r)
            rtc_out <= rtc_out + 32'h00000001;
        timers_run_out <= in_run || (mode_r == `PMS_MODE_START);
        output_inhibit_out <= !in_run;
        ao_level_out <= in_run ? 16'h0000 : safe_level(subst_en_r, subst_r);
        card_indicator_out <= (mode_r == `PMS_MODE_RELOAD);
        case (mode_r)
            `PMS_MODE_HOLD: begin
                run_indicator_out  <= blink_r;
                halt_indicator_out <= 1'b1;
            end
            `PMS_MODE_RUN: begin
                run_indicator_out  <= 1'b1;
                halt_indicator_out <= 1'b0;
            end
            `PMS_MODE_START: begin
                run_indicator_out  <= blink_r;
                halt_indicator_out <= 1'b0;
            end
            `PMS_MODE_ERASE: begin
                run_indicator_out  <= 1'b0;
                halt_indicator_out <= blink_r;
            end
            default: begin
                run_indicator_out  <= fw_pending_out & blink_r;
                // steady on after reset; blink while MRES is held, until HOLD_MS is reached
                halt_indicator_out <= (arm_r == ARM_IDLE && sw_mres) ?
                                      blink_r : 1'b1;
            end
        endcase
    end
end

endmodule // pms_sequencer

/* File: testbench/pms_panel_model.sv */
// Bouncing mode switch and card image model
`timescale 1ns/100ps
module pms_panel_model #(parameter BOUNCE = 3) (
    input  wire       clock_in,
    input  wire [1:0] pos_in,
    input  wire       card_in,
    output reg        sw_run_out,
    output reg        sw_mres_out,
    output reg        card_image_out
);
    reg [1:0] pos_r = 2'h0;
    reg [3:0] bnc_r = 4'h0;
    initial sw_run_out = 1'b0;
    initial sw_mres_out = 1'b0;
    initial card_image_out = 1'b0;
    always @(posedge clock_in) begin
        card_image_out <= card_in;
        if (pos_in != pos_r) begin
            pos_r <= pos_in;
            bnc_r <= BOUNCE;
        end else if (bnc_r != 4'h0) begin
            bnc_r <= bnc_r - 4'h1;
        end
        sw_run_out <= (bnc_r != 4'h0) ? ~sw_run_out : (pos_r == 2'h1);
        sw_mres_out <= (bnc_r != 4'h0) ? ~sw_mres_out : (pos_r == 2'h2);
    end
endmodule // pms_panel_model

/* File: testbench/pms_sequencer_asserts.sv */
// Port checker for the mode sequencer
`timescale 1ns/100ps
`include "pms_regs.vh"
module pms_sequencer_asserts #(parameter MS_CYCLES = 10) (
    input wire        clock_in,
    input wire        nrst_in,
    input wire        wb_cyc_in,
    input wire        wb_stb_in,
    input wire        wb_ack_out,
    input wire        halt_indicator_out,
    input wire        card_indicator_out,
    input wire        output_inhibit_out,
    input wire        core_reset_out,
    input wire        timers_run_out,
    input wire        erase_mem_out,
    input wire [2:0]  phase_out,
    input wire [2:0]  mode_out,
    input wire [31:0] rtc_out
);
    reg [15:0] still_r;
    reg [31:0] last_r;
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    // Cycles since the clock value last moved
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            still_r <= 16'h0000;
            last_r <= 32'h00000000;
        end else begin
            still_r <= (rtc_out == last_r) ? still_r + 16'h0001 : 16'h0000;
            last_r <= rtc_out;
        end
    end
    wire hold_w = (mode_out == `PMS_MODE_HOLD);
    hold_lamp_a: assert property (hold_w |-> halt_indicator_out)
        else $error("halt indicator dark in hold");
    hold_freeze_a: assert property (hold_w |-> !timers_run_out)
        else $error("timers running in hold");
    // First tick after reset lands one cycle later than the rest
    rtc_alive_a: assert property (still_r <= MS_CYCLES + 1)
        else $error("real-time clock stalled");
    hold_inhibit_a: assert property (hold_w |-> output_inhibit_out)
        else $error("outputs enabled in hold");
    wdog_stop_a: assert property (core_reset_out |-> ##[0:2]
        mode_out == `PMS_MODE_STOP) else $error("no stop after core reset");
    stop_inhibit_a: assert property (mode_out == `PMS_MODE_STOP
        |-> output_inhibit_out) else $error("outputs live in stop");
    run_release_a: assert property (mode_out == `PMS_MODE_RUN
        |-> !output_inhibit_out) else $error("inhibit held in run");
    cycle_order_a: assert property (phase_out == `PMS_PH_CYCLIC &&
        $past(phase_out) != `PMS_PH_CYCLIC |-> $past(phase_out) ==
        `PMS_PH_RD_IN) else $error("cyclic block before input read");
    erase_line_a: assert property (mode_out == `PMS_MODE_ERASE
        |-> $past(erase_mem_out)) else $error("erase line low");
    reload_lamp_a: assert property (mode_out == `PMS_MODE_RELOAD
        |-> card_indicator_out) else $error("card lamp dark");
    bus_answer_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
        |=> wb_ack_out ##1 !wb_ack_out) else $error("bad ack pulse");
    hold_c: cover property (hold_w);
    erase_c: cover property (mode_out == `PMS_MODE_ERASE);
    wdog_c: cover property (core_reset_out);
endmodule // pms_sequencer_asserts
bind pms_sequencer pms_sequencer_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (.*);

/* File: testbench/pms_sequencer_tb.sv */
// Self-checking bench for the mode sequencer
`timescale 1ns/100ps
`include "pms_regs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module pms_sequencer_tb;
    localparam MS = 10;
    localparam HOLD = 20;
    reg clock_in = 0, nrst_in = 0, wb_cyc_in = 0, wb_stb_in = 0;
    reg wb_we_in = 0, card = 0;
    reg [7:0] wb_adr_in = 0, remote_in = 0;
    reg [3:0] wb_sel_in = 0;
    reg [31:0] wb_dat_in = 0, rd, seed = 32'h25144cc4;
    reg [1:0] pos = 0;
    wire sw_run_in, sw_mres_in, card_image_in;
    wire card_pkg_in = 1'b1;
    wire [15:0] card_pkg_prefix_in = `PMS_PKG_PREFIX;
    wire [23:0] card_pkg_ver_in = 24'h000002, fw_ver_in = 24'h000001;
    wire wb_ack_out, run_indicator_out, halt_indicator_out, erase_mem_out;
    wire card_indicator_out, output_inhibit_out, core_reset_out;
    wire timers_run_out, fw_pending_out;
    wire [2:0] phase_out, mode_out;
    wire [15:0] ao_level_out;
    wire [7:0] remote_image_out;
    wire [31:0] wb_dat_out, rtc_out;
    integer mismatches = 0, compares = 0, cycles = 0, i, cnt;
    always #20 clock_in = ~clock_in;
    pms_sequencer #(.MS_CYCLES(MS), .WDOG_MS(100), .HOLD_MS(HOLD),
        .DEB_MS(2), .BLINK_MS(4)) u_dut (.*);
    pms_panel_model u_panel (.clock_in(clock_in), .pos_in(pos),
        .card_in(card), .sw_run_out(sw_run_in), .sw_mres_out(sw_mres_in),
        .card_image_out(card_image_in));
    task wb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clock_in);
            {wb_cyc_in, wb_stb_in, wb_we_in, wb_sel_in} <= {2'b11, w, 4'hf};
            wb_adr_in <= a;
            wb_dat_in <= d;
            do @(posedge clock_in);
            while (wb_ack_out !== 1'b1);
            rd = wb_dat_out;
            {wb_cyc_in, wb_stb_in} <= 2'b00;
        end
    endtask
    task wait_mode(input [2:0] m, input integer lim);
        integer n;
        for (n = 0; mode_out !== m && n < lim; n = n + 1)
            @(posedge clock_in);
        `CHK("mode", m, mode_out)
    endtask
    task move(input [1:0] p, input integer ms);
        begin
            pos <= p;
            repeat (ms * MS) @(posedge clock_in);
        end
    endtask
    task start_run;
        begin
            wb(1, `PMS_CYC_LIM_ADDR, 32'd1000);
            move(1, 4);
            wait_mode(`PMS_MODE_START, 50);
            `CHK("start inhibit", 1'b1, output_inhibit_out)
            wb(1, `PMS_CTRL_ADDR, 32'h21);
            wait_mode(`PMS_MODE_RUN, 50);
            `CHK("run inhibit", 1'b0, output_inhibit_out)
            `CHK("run lamp", 1'b1, run_indicator_out)
        end
    endtask
    task summarize;
        begin
            if (mismatches == 0 && compares > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    always @(posedge clock_in) begin
        cycles = cycles + 1;
        if (cycles == 30000) begin
            mismatches = mismatches + 1;
            summarize;
        end
    end
    initial begin
        repeat (4) @(posedge clock_in);
        nrst_in <= 1;
        repeat (2) @(posedge clock_in);
        wb(0, `PMS_MPI_ADDR, 0);
        `CHK("station", 32'h2, rd)
        wb(0, 8'h40, 0);
        `CHK("unmapped", 32'h0, rd)
        wb(1, `PMS_CYC_LIM_ADDR, 0);
        wb(0, `PMS_CYC_LIM_ADDR, 0);
        `CHK("limit", 32'h1, rd)
        wait_mode(`PMS_MODE_STOP, 5);
        for (i = 0; fw_pending_out !== 1'b1 && i < 100; i = i + 1)
            @(posedge clock_in);
        `CHK("fw pending", 1'b1, fw_pending_out)
        remote_in <= $random(seed);
        repeat (2 * MS) @(posedge clock_in);
        `CHK("remote", remote_in, remote_image_out)
        wb(1, `PMS_SUBST_ADDR, 32'h1234);
        wb(1, `PMS_CTRL_ADDR, 32'h200);
        repeat (2) @(posedge clock_in);
        `CHK("subst", 16'h1234, ao_level_out)
        wb(1, `PMS_CTRL_ADDR, 32'h0);
        repeat (2) @(posedge clock_in);
        `CHK("safe", 16'h0, ao_level_out)
        start_run;
        for (i = 0; i < 3; i = i + 1) begin
            cnt = (i == 2) ? 3 : (i == 0) ? 2 : $random(seed) & 1;
            wb(1, `PMS_CTRL_ADDR, (cnt << 12) | 32'h5);
            wait_mode(`PMS_MODE_HOLD, 20);
            `CHK("hold", `PMS_MODE_HOLD, mode_out)
            wb(1, `PMS_CTRL_ADDR, (cnt << 12) | 32'h11);
            wb(0, `PMS_STAT_ADDR, 0);
            `CHK("refused", cnt > 2, rd[10])
            wb(1, `PMS_CTRL_ADDR, 32'h9);
            wait_mode(`PMS_MODE_RUN, 20);
        end
        wb(1, `PMS_CYC_LIM_ADDR, 32'h1);
        wait_mode(`PMS_MODE_STOP, 100);
        wb(0, `PMS_STAT_ADDR, 0);
        `CHK("cycle trip", 1'b1, rd[9])
        move(0, 4);
        start_run;
        for (i = 0; core_reset_out !== 1'b1 && i < 1100; i = i + 1)
            @(posedge clock_in);
        `CHK("core reset", 1'b1, core_reset_out)
        wait_mode(`PMS_MODE_STOP, 5);
        wb(0, `PMS_STAT_ADDR, 0);
        `CHK("wdog trip", 1'b1, rd[8])
        move(0, 4);
        move(2, HOLD + 4);
        move(0, HOLD + 6);
        move(2, 4);
        move(0, 4);
        `CHK("no erase", 1'b0, erase_mem_out)
        card <= 1;
        move(2, HOLD + 4);
        move(0, 4);
        move(2, 4);
        move(0, 2);
        wait_mode(`PMS_MODE_ERASE, 100);
        `CHK("erase", 1'b1, erase_mem_out)
        wb(1, `PMS_CTRL_ADDR, 32'h400);
        wait_mode(`PMS_MODE_RELOAD, 20);
        `CHK("card lamp", 1'b1, card_indicator_out)
        wb(1, `PMS_CTRL_ADDR, 32'h40);
        wait_mode(`PMS_MODE_STOP, 20);
        `CHK("after load", `PMS_MODE_STOP, mode_out)
        `CHK("card off", 1'b0, card_indicator_out)
        summarize;
    end
endmodule // pms_sequencer_tb
